// ===== hw/mswg_pkg.sv
/*
 mswg_pkg: constants and types of the code sequencer.
 Assumes a 125 MHz clock and byte addresses on a 32-bit APB.
*/
package mswg_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 125;   // system clock rate
   localparam int unsigned TMO_US  = 25000; // link clock-low timeout
   // ---------------------------------------------------------------
   // register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] A_IFCFG = 8'h00;  // link enable, address
   localparam logic [7:0] A_FUNC0 = 8'h04;  // channel 0 function cfg
   localparam logic [7:0] A_FUNC1 = 8'h08;  // channel 1 function cfg
   localparam logic [7:0] A_MARG0 = 8'h0c;  // channel 0 margin codes
   localparam logic [7:0] A_MARG1 = 8'h10;  // channel 1 margin codes
   localparam logic [7:0] A_CODE  = 8'h14;  // live codes and on state
   localparam logic [7:0] A_STAT  = 8'h18;  // fault flag and page
   localparam int F_EN = 0, F_ADDR = 8;
   localparam int F_PER = 0, F_STEP = 4, F_WAVE = 8, F_WEN = 12;
   localparam int F_LOW = 0, F_HIGH = 16, F_ON = 12;
   localparam logic [6:0] RST_TADDR = 7'h48; // target address at reset
   // ---------------------------------------------------------------
   // link commands and operation codes
   // ---------------------------------------------------------------
   localparam logic [7:0] C_PAGE = 8'h00, C_OP = 8'h01;
   localparam logic [7:0] C_CML = 8'h7e, C_REV = 8'h98;
   localparam logic [7:0] OP_OFF = 8'h00, OP_ON = 8'h80;
   localparam logic [7:0] OP_LOW = 8'h94, OP_HIGH = 8'ha4;
   localparam logic [7:0] P_CH0 = 8'h00, P_CH1 = 8'h01;
   localparam int CML_BIT = 1;
   localparam logic [2:0] W_TRI = 3'h0, W_SAW = 3'h1, W_INV = 3'h2;
   // step period in ns, 0 = no slew
   localparam int unsigned STEP_NS [16] = '{0, 4000, 8000, 12000, 18000,
      27000, 40500, 60750, 91130, 136690, 239200, 418610, 732560,
      1281980, 2563960, 5127920};
   localparam logic [5:0] STEP_LSB [8] = '{6'h01, 6'h02, 6'h03, 6'h04,
      6'h06, 6'h08, 6'h10, 6'h20};
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_RX = 3'b010,
      ST_ACK = 3'b011, ST_TX = 3'b100, ST_HACK = 3'b101
   } mswg_st_e;
   typedef struct packed {
      logic [3:0]  per_sel;
      logic [2:0]  step_sel;
      logic [2:0]  wave_sel;
      logic        wave_en;
      logic [11:0] low;
      logic [11:0] high;
   } mswg_cfg_s;
endpackage : mswg_pkg

// ===== hw/mswg_top.sv
/*
 mswg_top: two-channel code sequencer, APB registers, link target.
 Assumes raw scl/sda pins and sda resolved outside from sda_oe.
*/
// The register addresses and the APB register port were left to the implementer.
// How it works
// [RQ1] period field selects no slew or 4..5127.92us
// [RQ2] slew moves one step per period
// [RQ3] step field gives 1,2,3,4,6,8,16,32 LSB
// [RQ4] link commands only when protocol enabled
// [RQ5] start, address plus write, every byte acked
// [RQ6] host sends command code second
// [RQ7] write data arrives low byte first
// [RQ8] read after repeated start, low byte first
// [RQ9] operation 00h off, 80h on
// [RQ10] 94h/A4h slew to low/high margin
// [RQ11] host selects page before channel command
// [RQ12] group command at stop, clock-low timeout
// [RQ13] fault flag set on fault, write-1 clears
// [RQ14] revision command returns supported revision
// [RQ15] each channel runs its own waveform
// [RQ16] wave 000 is triangle low to high
// [RQ17] triangle period 2*T*ceil(span/step)
// [RQ18] sawtooths span low to high margin
// [RQ19] wave 001 rising, 010 falling sawtooth
// [RQ20] sawtooth period T*ceil(span/step+1)
// [RQ21] triangle reverses, sawtooths jump back
// [RQ22] overshooting steps clamp to limit
`timescale 1ns/1ps
module mswg_top #(
   parameter int unsigned PERIOD_DIV = 1, // shortens step periods
   parameter int unsigned TMO_CYC = mswg_pkg::TMO_US * mswg_pkg::CLK_MHZ,
   parameter logic [7:0]  PM_REV = 8'h22  // arbitrary revision value
) (
   input  wire logic              mclk,     // 125 MHz clock
   input  wire logic              rst_b,    // async reset, low active
   input  wire logic              psel,     // apb select
   input  wire logic              penable,  // apb access phase
   input  wire logic              pwrite,   // apb write
   input  wire logic [7:0]        paddr,    // apb byte address
   input  wire logic [31:0]       pwdata,   // apb write data
   output logic      [31:0]       prdata,   // apb read data
   output logic                   pready,   // apb ready
   output logic                   pslverr,  // apb unmapped address
   input  wire logic              scl_in,   // link clock pin
   input  wire logic              sda_in,   // link data pin level
   output logic                   sda_out,  // link data drive value
   output logic                   sda_oe,   // link data pulls low
   output logic      [1:0][11:0]  ch_code,  // channel output codes
   output logic      [1:0]        ch_on     // channel output on
);
   initial
   begin
      if (PERIOD_DIV == 0 || TMO_CYC < 2 || TMO_CYC >= 32'h0040_0000)
         $error("mswg_top: bad parameter");
   end
   // ---------------------------------------------------------------
   // registers and link state
   // ---------------------------------------------------------------
   mswg_pkg::mswg_cfg_s  cfg_reg [2];
   mswg_pkg::mswg_st_e   st_reg;
   logic        en_reg, fault_reg, rd_reg, pend_vld_reg, pend_go_reg;
   logic        pend_ch_reg, scl_q_reg, sda_q_reg, oe_reg;
   logic [6:0]  taddr_reg;
   logic [1:0]  scl_sy_reg, sda_sy_reg, nb_reg;
   logic [3:0]  bit_reg;
   logic [7:0]  sh_reg, cmd_reg, page_reg, oplo_reg, pend_code_reg;
   logic [15:0] op_reg [2];
   logic [21:0] tmo_reg;
   logic [11:0] code_reg [2];
   logic [1:0]  on_reg;
   logic [31:0] rd_mux;
   logic [7:0]  txb;
   logic        scl, sda, s_rise, s_fall, s_start, s_stop, tmo_hit;
   logic        wr_en, apb_clr, hit;

   // step period in cycles, at least one
   function automatic logic [19:0] per_cyc(input logic [3:0] sel);
      int unsigned c;
      c = (mswg_pkg::STEP_NS[sel] * mswg_pkg::CLK_MHZ + 999) / 1000;
      c = c / PERIOD_DIV;
      return (c == 0) ? 20'h00001 : c[19:0];
   endfunction : per_cyc

   // step up, clamped
   function automatic logic [11:0] up_c(input logic [11:0] v,
      input logic [5:0] s, input logic [11:0] lim);
      logic [12:0] n;
      n = {1'b0, v} + {7'h00, s};
      return (n >= {1'b0, lim}) ? lim : n[11:0];
   endfunction : up_c

   // step down, clamped
   function automatic logic [11:0] dn_c(input logic [11:0] v,
      input logic [5:0] s, input logic [11:0] lim);
      return ({1'b0, v} <= {1'b0, lim} + {7'h00, s}) ? lim :
         v - {6'h00, s};
   endfunction : dn_c

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   assign wr_en = psel & penable & pready & pwrite;
   assign apb_clr = wr_en && paddr == mswg_pkg::A_STAT && pwdata[0];
   // read mux, unmapped reads zero with error
   always_comb
   begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         mswg_pkg::A_IFCFG: rd_mux = {17'h0, taddr_reg, 7'h00, en_reg};
         mswg_pkg::A_FUNC0, mswg_pkg::A_FUNC1:
         begin
            rd_mux[mswg_pkg::F_PER +: 4] = cfg_reg[paddr[3]].per_sel;
            rd_mux[mswg_pkg::F_STEP +: 3] = cfg_reg[paddr[3]].step_sel;
            rd_mux[mswg_pkg::F_WAVE +: 3] = cfg_reg[paddr[3]].wave_sel;
            rd_mux[mswg_pkg::F_WEN] = cfg_reg[paddr[3]].wave_en;
         end
         mswg_pkg::A_MARG0: rd_mux = {4'h0, cfg_reg[0].high, 4'h0,
            cfg_reg[0].low};
         mswg_pkg::A_MARG1: rd_mux = {4'h0, cfg_reg[1].high, 4'h0,
            cfg_reg[1].low};
         mswg_pkg::A_CODE: rd_mux = {3'h0, on_reg[1], code_reg[1], 3'h0,
            on_reg[0], code_reg[0]};
         mswg_pkg::A_STAT: rd_mux = {16'h0, page_reg, 7'h00, fault_reg};
         default: hit = 1'b0;
      endcase
   end

   // one access cycle, data latched at setup
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         if (psel & ~penable)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit;
         end
      end
   end

   // software configuration
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         en_reg <= 1'b0;
         taddr_reg <= mswg_pkg::RST_TADDR;
         cfg_reg[0] <= '0;
         cfg_reg[1] <= '0;
      end
      else if (wr_en)
      begin
         case (paddr)
            mswg_pkg::A_IFCFG:
            begin
               en_reg <= pwdata[mswg_pkg::F_EN];
               taddr_reg <= pwdata[mswg_pkg::F_ADDR +: 7];
            end
            mswg_pkg::A_FUNC0, mswg_pkg::A_FUNC1:
            begin
               cfg_reg[paddr[3]].per_sel <= pwdata[mswg_pkg::F_PER +: 4];
               cfg_reg[paddr[3]].step_sel <= pwdata[mswg_pkg::F_STEP +: 3];
               cfg_reg[paddr[3]].wave_sel <= pwdata[mswg_pkg::F_WAVE +: 3];
               cfg_reg[paddr[3]].wave_en <= pwdata[mswg_pkg::F_WEN];
            end
            mswg_pkg::A_MARG0, mswg_pkg::A_MARG1:
            begin
               cfg_reg[paddr[4]].low <= pwdata[mswg_pkg::F_LOW +: 12];
               cfg_reg[paddr[4]].high <= pwdata[mswg_pkg::F_HIGH +: 12];
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // link pins: synchronisers, edges, frames
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_sy_reg <= 2'b11;
         sda_sy_reg <= 2'b11;
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end
      else
      begin
         scl_sy_reg <= {scl_sy_reg[0], scl_in};
         sda_sy_reg <= {sda_sy_reg[0], sda_in};
         scl_q_reg <= scl_sy_reg[1];
         sda_q_reg <= sda_sy_reg[1];
      end
   end
   assign scl = scl_sy_reg[1];
   assign sda = sda_sy_reg[1];
   assign s_rise = scl & ~scl_q_reg;
   assign s_fall = ~scl & scl_q_reg;
   assign s_start = scl & scl_q_reg & sda_q_reg & ~sda;
   assign s_stop = scl & scl_q_reg & ~sda_q_reg & sda;
   assign tmo_hit = tmo_reg == 22'(TMO_CYC - 1);

   // clock-low watchdog inside frames
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         tmo_reg <= '0;
      else if (scl || st_reg == mswg_pkg::ST_IDLE || tmo_hit)
         tmo_reg <= '0;
      else
         tmo_reg <= tmo_reg + 22'h000001; // [RQ12]
   end

   // read byte, operation low byte first
   always_comb
   begin
      case (cmd_reg)
         mswg_pkg::C_PAGE: txb = page_reg;
         mswg_pkg::C_CML: txb = 8'(fault_reg) << mswg_pkg::CML_BIT;
         mswg_pkg::C_REV: txb = PM_REV; // [RQ14]
         mswg_pkg::C_OP: txb = nb_reg[0] ? op_reg[page_reg[0]][15:8] :
            op_reg[page_reg[0]][7:0]; // [RQ8]
         default: txb = 8'hff;
      endcase
   end

   // ---------------------------------------------------------------
   // link target state machine
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= mswg_pkg::ST_IDLE;
         {oe_reg, rd_reg, fault_reg, pend_vld_reg, pend_go_reg} <= '0;
         {pend_ch_reg, bit_reg, nb_reg, sh_reg, cmd_reg} <= '0;
         {page_reg, oplo_reg, pend_code_reg} <= '0;
         op_reg[0] <= '0;
         op_reg[1] <= '0;
      end
      else
      begin
         pend_go_reg <= 1'b0;
         if (apb_clr)
            fault_reg <= 1'b0;
         if (tmo_hit)
         begin
            st_reg <= mswg_pkg::ST_IDLE;
            oe_reg <= 1'b0;
            pend_vld_reg <= 1'b0;
            fault_reg <= 1'b1; // [RQ12] [RQ13]
         end
         else if (!en_reg)
         begin
            st_reg <= mswg_pkg::ST_IDLE; // [RQ4]
            oe_reg <= 1'b0;
         end
         else if (s_start)
         begin
            st_reg <= mswg_pkg::ST_ADDR; // [RQ5]
            bit_reg <= '0;
            nb_reg <= '0;
            oe_reg <= 1'b0;
         end
         else if (s_stop)
         begin
            // group command acts at the stop
            st_reg <= mswg_pkg::ST_IDLE;
            oe_reg <= 1'b0;
            pend_go_reg <= pend_vld_reg; // [RQ12]
            pend_vld_reg <= 1'b0;
         end
         else if (s_rise)
         begin
            case (st_reg)
               mswg_pkg::ST_ADDR, mswg_pkg::ST_RX:
               begin
                  sh_reg <= {sh_reg[6:0], sda};
                  bit_reg <= bit_reg + 4'h1;
               end
               mswg_pkg::ST_TX: bit_reg <= bit_reg + 4'h1;
               mswg_pkg::ST_HACK:
               begin
                  nb_reg <= nb_reg + 2'h1;
                  if (sda)
                     st_reg <= mswg_pkg::ST_IDLE; // host ends the read
               end
               default: ;
            endcase
         end
         else if (s_fall)
         begin
            case (st_reg)
               mswg_pkg::ST_ADDR:
               begin
                  if (bit_reg == 4'h8 && sh_reg[7:1] == taddr_reg)
                  begin
                     st_reg <= mswg_pkg::ST_ACK; // [RQ5]
                     oe_reg <= 1'b1;
                     rd_reg <= sh_reg[0];
                  end
                  else if (bit_reg == 4'h8)
                     st_reg <= mswg_pkg::ST_IDLE;
               end
               mswg_pkg::ST_RX:
               begin
                  if (bit_reg == 4'h8)
                  begin
                     st_reg <= mswg_pkg::ST_ACK; // [RQ5]
                     oe_reg <= 1'b1;
                     nb_reg <= nb_reg + 2'h1;
                     if (nb_reg == 2'h0)
                     begin
                        cmd_reg <= sh_reg; // [RQ6]
                        if (sh_reg != mswg_pkg::C_PAGE &&
                            sh_reg != mswg_pkg::C_OP &&
                            sh_reg != mswg_pkg::C_CML &&
                            sh_reg != mswg_pkg::C_REV)
                           fault_reg <= 1'b1; // [RQ13]
                     end
                     else if (nb_reg == 2'h1)
                     begin
                        case (cmd_reg)
                           mswg_pkg::C_PAGE:
                           begin
                              page_reg <= sh_reg; // [RQ11]
                              if (sh_reg != mswg_pkg::P_CH0 &&
                                  sh_reg != mswg_pkg::P_CH1)
                                 fault_reg <= 1'b1;
                           end
                           mswg_pkg::C_CML:
                              if (sh_reg[mswg_pkg::CML_BIT] && !apb_clr)
                                 fault_reg <= 1'b0; // [RQ13]
                           mswg_pkg::C_OP: oplo_reg <= sh_reg; // [RQ7]
                           default: ;
                        endcase
                     end
                     else if (nb_reg == 2'h2 && cmd_reg == mswg_pkg::C_OP)
                     begin
                        op_reg[page_reg[0]] <= {sh_reg, oplo_reg}; // [RQ7]
                        pend_vld_reg <= 1'b1;
                        pend_ch_reg <= page_reg[0]; // [RQ11]
                        pend_code_reg <= sh_reg;
                     end
                  end
               end
               mswg_pkg::ST_ACK:
               begin
                  bit_reg <= '0;
                  if (rd_reg)
                  begin
                     st_reg <= mswg_pkg::ST_TX; // [RQ8]
                     sh_reg <= txb;
                     oe_reg <= ~txb[7];
                  end
                  else
                  begin
                     st_reg <= mswg_pkg::ST_RX;
                     oe_reg <= 1'b0;
                  end
               end
               mswg_pkg::ST_TX:
               begin
                  if (bit_reg == 4'h8)
                  begin
                     st_reg <= mswg_pkg::ST_HACK;
                     oe_reg <= 1'b0;
                  end
                  else
                  begin
                     oe_reg <= ~sh_reg[6];
                     sh_reg <= {sh_reg[6:0], 1'b1};
                  end
               end
               mswg_pkg::ST_HACK:
               begin
                  st_reg <= mswg_pkg::ST_TX; // [RQ8]
                  bit_reg <= '0;
                  sh_reg <= txb;
                  oe_reg <= ~txb[7];
               end
               default: st_reg <= mswg_pkg::ST_IDLE;
            endcase
         end
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;

   // ---------------------------------------------------------------
   // channel engines
   // ---------------------------------------------------------------
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      mswg_pkg::mswg_cfg_s cf;
      logic [19:0] per, cnt_reg;
      logic [5:0]  stp;
      logic [11:0] tgt_reg, sl_nx, t;
      logic        go, tick, slew_reg, up_reg;
      assign cf = cfg_reg[c];
      assign per = per_cyc(cf.per_sel); // [RQ1]
      assign stp = mswg_pkg::STEP_LSB[cf.step_sel]; // [RQ3]
      assign go = pend_go_reg && pend_ch_reg == 1'(c);
      assign tick = cnt_reg == 20'h00000;
      assign t = (pend_code_reg == mswg_pkg::OP_LOW) ? cf.low : cf.high;
      assign sl_nx = (code_reg[c] < tgt_reg) ?
         up_c(code_reg[c], stp, tgt_reg) : dn_c(code_reg[c], stp, tgt_reg);

      // step timer, realigned by operations
      always_ff @(posedge mclk or negedge rst_b)
      begin
         if (!rst_b)
            cnt_reg <= '0;
         else if (go || tick)
            cnt_reg <= per - 20'h00001; // [RQ2]
         else
            cnt_reg <= cnt_reg - 20'h00001;
      end

      // operation, else wave, else slew
      always_ff @(posedge mclk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            code_reg[c] <= '0;
            on_reg[c] <= 1'b0;
            tgt_reg <= '0;
            slew_reg <= 1'b0;
            up_reg <= 1'b1;
         end
         else if (go)
         begin
            case (pend_code_reg)
               mswg_pkg::OP_OFF: on_reg[c] <= 1'b0; // [RQ9]
               mswg_pkg::OP_ON: on_reg[c] <= 1'b1; // [RQ9]
               mswg_pkg::OP_LOW, mswg_pkg::OP_HIGH:
               begin
                  tgt_reg <= t; // [RQ10]
                  if (cf.per_sel == 4'h0)
                  begin
                     code_reg[c] <= t; // [RQ1]
                     slew_reg <= 1'b0;
                  end
                  else
                     slew_reg <= 1'b1;
               end
               default: ;
            endcase
         end
         else if (cf.wave_en && tick)
         begin
            // [RQ15] [RQ18]
            case (cf.wave_sel)
               mswg_pkg::W_TRI: // [RQ16] [RQ17] [RQ21] [RQ22]
               begin
                  if (up_reg)
                  begin
                     code_reg[c] <= up_c(code_reg[c], stp, cf.high);
                     if (up_c(code_reg[c], stp, cf.high) == cf.high)
                        up_reg <= 1'b0;
                  end
                  else
                  begin
                     code_reg[c] <= dn_c(code_reg[c], stp, cf.low);
                     if (dn_c(code_reg[c], stp, cf.low) == cf.low)
                        up_reg <= 1'b1;
                  end
               end
               mswg_pkg::W_SAW: // [RQ19] [RQ20] [RQ21] [RQ22]
                  code_reg[c] <= (code_reg[c] == cf.high) ? cf.low :
                     up_c(code_reg[c], stp, cf.high);
               mswg_pkg::W_INV: // [RQ19] [RQ20] [RQ21] [RQ22]
                  code_reg[c] <= (code_reg[c] == cf.low) ? cf.high :
                     dn_c(code_reg[c], stp, cf.low);
               default: ;
            endcase
         end
         else if (slew_reg && tick)
         begin
            code_reg[c] <= sl_nx; // [RQ2]
            if (sl_nx == tgt_reg)
               slew_reg <= 1'b0;
         end
      end
   end
   assign ch_code = {code_reg[1], code_reg[0]};
   assign ch_on = on_reg;
endmodule : mswg_top

// ===== test/mswg_monitor.sv
/* mswg_monitor: port checks of mswg_top.
   Assumes a slow link host. */
`timescale 1ns/1ps
module mswg_monitor (
   input wire logic        mclk,    // clock
   input wire logic        rst_b,   // reset
   input wire logic        psel,    // select
   input wire logic        penable, // access
   input wire logic        pwrite,  // write
   input wire logic [7:0]  paddr,   // address
   input wire logic [31:0] prdata,  // read data
   input wire logic        pready,  // ready
   input wire logic        pslverr, // error
   input wire logic        scl_in,  // link clock
   input wire logic        sda_oe   // link pull
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // one-cycle ready, only after setup
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_has_cause:
      assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   // map ends at 0x18
   a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("unmapped not refused");
   a_err_mapped:
      assert property (pready && paddr < 8'h1c && paddr[1:0] == 2'h0
         |-> !pslverr) else $error("mapped refused");
   a_err_reads_zero:
      assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_rdata_holds: assert property (!pready |-> $stable(prdata))
      else $error("read data moved");
   // sda moves only with scl low, else a false start/stop
   a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda moved with scl high");
endmodule : mswg_monitor
bind mswg_top mswg_monitor i_mswg_monitor (.mclk(mclk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
   .sda_oe(sda_oe));

// ===== test/mswg_host_model.sv
/* mswg_host_model: link host, 10 mclk a bit, scl idle high.
   Assumes a pulled-up, open-drain sda. */
`timescale 1ns/1ps
module mswg_host_model (
   input  wire logic mclk,   // pacing clock
   input  wire logic sda_oe, // target pulls sda low
   output logic      scl,    // link clock
   output logic      sda     // resolved wire
);
   localparam logic [7:0] AW = {mswg_pkg::RST_TADDR, 1'b0};
   logic hd = 1'b1; // host drive, 1 = released
   assign sda = hd & ~sda_oe; // pull-up
   initial scl = 1'b1;
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
   endtask : w
   // data moves one cycle before scl rises
   task automatic bx(input logic b, output logic r);
      w(4);
      hd <= b;
      w(1);
      scl <= 1'b1;
      w(5);
      r = sda;
      scl <= 1'b0;
   endtask : bx
   // start (1,0) or stop (0,1)
   task automatic fr(input logic a, input logic b);
      w(4);
      hd <= a;
      w(1);
      scl <= 1'b1;
      w(5);
      hd <= b;
      w(5);
      scl <= b;
   endtask : fr
   task automatic bs(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bx(d[i], r);
      bx(1'b1, r);
      ok &= !r;
   endtask : bs
   task automatic br(input logic nk, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
      bx(nk, r);
   endtask : br
   task automatic wr(input logic [7:0] c, input int n,
      input logic [15:0] d, output logic ok);
      ok = 1'b1;
      fr(1'b1, 1'b0);
      bs(AW, ok);
      bs(c, ok);
      if (n > 0) bs(d[7:0], ok);
      if (n > 1) bs(d[15:8], ok);
      fr(1'b0, 1'b1);
   endtask : wr
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      logic ok;
      fr(1'b1, 1'b0);
      bs(AW, ok);
      bs(c, ok);
      fr(1'b1, 1'b0);
      bs(AW | 8'h01, ok);
      br(1'b0, d[7:0]);
      br(1'b1, d[15:8]);
      fr(1'b0, 1'b1);
   endtask : rd
endmodule : mswg_host_model

// ===== test/mswg_top_tb.sv
/* mswg_top_tb: apb and link tests, step periods cut by 100.
   Assumes the host model and the bound monitor. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: %h, expected %h", $time, a, e); end end
module mswg_top_tb;
   logic             mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic             pready, pslverr, err, ok, scl, sda, sda_oe;
   logic [1:0][11:0] ch_code;
   logic [1:0]       ch_on;
   logic [15:0]      lk;
   logic [11:0]      x;
   int               miscompares = 0, n_checks = 0, cyc = 0;
   always #4 mclk = ~mclk;
   mswg_top #(.PERIOD_DIV(100), .TMO_CYC(200)) i_mswg_top (.mclk(mclk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe), .ch_code(ch_code), .ch_on(ch_on));
   mswg_host_model i_mswg_host_model (.mclk(mclk), .sda_oe(sda_oe),
      .scl(scl), .sda(sda));
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      {err, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic lw(input logic [7:0] c, input int n, input logic [15:0] d);
      i_mswg_host_model.wr(c, n, d, ok);
      `CHK(ok, 1'b1)
   endtask : lw
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // hang guard, the run needs a few thousand cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      apb(0, mswg_pkg::A_IFCFG, 0);
      `CHK(rd, 32'h0000_4800)
      i_mswg_host_model.wr(mswg_pkg::C_PAGE, 1, 16'h0001, ok);
      `CHK(ok, 1'b0)
      apb(1, mswg_pkg::A_IFCFG, 32'h0000_4801);
      apb(0, 8'h1c, 0);
      `CHK({err, rd}, 33'h1_0000_0000)
      apb(1, mswg_pkg::A_MARG1, 32'h0050_0010);
      apb(1, mswg_pkg::A_FUNC1, 32'h0000_0072);
      lw(mswg_pkg::C_PAGE, 1, 16'h0001);
      lw(mswg_pkg::C_OP, 2, 16'ha400);
      for (int i = 0; i < 200 && ch_code[1] === 12'h0; i++) @(negedge mclk);
      `CHK(ch_code[1], 12'h020)
      repeat (10) @(negedge mclk);
      `CHK(ch_code[1], 12'h040)
      repeat (10) @(negedge mclk);
      `CHK({ch_on[1], ch_code[1]}, 13'h0050)
      i_mswg_host_model.rd(mswg_pkg::C_OP, lk);
      `CHK(lk, 16'ha400)
      i_mswg_host_model.rd(mswg_pkg::C_REV, lk);
      `CHK(lk[7:0], 8'h22)
      lw(mswg_pkg::C_OP, 2, 16'h8000);
      repeat (10) @(negedge mclk);
      `CHK(ch_on, 2'b10)
      lw(mswg_pkg::C_OP, 2, 16'h0000);
      repeat (10) @(negedge mclk);
      `CHK(ch_on, 2'b00)
      lw(8'h55, 0, 16'h0000);
      apb(0, mswg_pkg::A_STAT, 0);
      `CHK(rd, 32'h0000_0101)
      apb(1, mswg_pkg::A_STAT, 32'h1);
      apb(0, mswg_pkg::A_STAT, 0);
      `CHK(rd, 32'h0000_0100)
      // ch0 waves over 0..4, ch1 stays parked
      apb(1, mswg_pkg::A_MARG0, 32'h0004_0000);
      for (int s = 0; s < 3; s++)
      begin
         apb(1, mswg_pkg::A_FUNC0, 32'h1000 | 32'(s << 8));
         repeat (20) @(negedge mclk);
         x = ch_code[0];
         `CHK(x <= 12'h004, 1'b1)
         repeat (s == 0 ? 8 : 5) @(negedge mclk);
         `CHK(ch_code[0], x)
         @(negedge mclk);
         `CHK(ch_code[0] !== x, 1'b1)
         `CHK(ch_code[1], 12'h050)
      end
      report_and_stop;
   end
endmodule : mswg_top_tb
